// ===== hdl/tro_opcode_ctrl.sv
// Opcode interpreter behind one 16-bit command word, reached over AXI4-Lite
// Operation
// - Stall new commands until all parameters moved
// - Set dead time from two low bits
// - Read dead time setting back
// - Include or exclude header and trailer
// - Read header/trailer enable in bit zero
// - Set hit limit code, 1001 unlimited
// - Over limit: error word before trailer
// - Read hit limit code back
// - Error mark on global error on/off
// - Bypass on global error on/off
// - Set eleven error type enables
// - Read eleven error type enables
// - Set buffer depth code, default 111
// - Read buffer depth code back
// - Channel enables apply during running acquisition
// - Enable one channel by index
// - Disable one channel by index
// - Enable or disable all channels
// - Write eight mask words, bit per channel
// - Read eight mask words, same mapping
// - Write two mask words for one TDC
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module tro_opcode_ctrl
  import tro_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic hit_in, // One hit of the current event
  input wire logic event_end, // Last cycle of the current event
  input wire logic [ERR_TYPES-1:0] tdc_err, // Internal error types
  output logic hit_accept, // Hit kept within the limit
  output logic err_word_valid, // Error word at event end
  output logic [15:0] err_word, // Error word flags
  output logic trailer_valid, // Trailer slot after the event
  output logic global_err, // Masked global error
  output logic err_mark, // Mark events with error
  output logic tdc_bypass, // Bypass on global error
  output tro_cfg_t cfg // Live configuration
);

  tro_state_t state;
  logic [15:0] opcode;
  logic [2:0] word_idx;
  logic [2:0] last_idx;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [15:0] w_data;
  logic w_lane_ok;
  logic do_write;
  logic [7:0] cmd_op;
  logic [7:0] cur_op;
  logic [3:0] cur_tdc;
  logic [15:0] param_rd;
  logic rd_cmd;
  logic [8:0] hit_cnt;
  logic [8:0] hit_cap;
  logic over_limit;
  logic pend_trailer;
  logic [1:0] dead_code;
  logic [3:0] dead_cycles;
  logic hdr_trl_en, err_mark_en, bypass_en;
  logic [3:0] hit_limit;
  logic [ERR_TYPES-1:0] err_type_en;
  logic [2:0] buf_size;
  logic [NUM_CH-1:0] chan_en;

  // Settings leave as one packed word, in field order, so each field keeps one driver
  assign cfg = {dead_code, dead_cycles, hdr_trl_en, hit_limit, err_mark_en,
    bypass_en, err_type_en, buf_size, chan_en};

  // Write address and data are taken independently and held until answered
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign cmd_op = w_data[15:8];
  assign cur_op = opcode[15:8];
  assign cur_tdc = opcode[3:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Only a full low half-word counts as a command word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 16'h0000;
      w_lane_ok <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata[15:0];
      w_lane_ok <= &s_axi_wstrb[1:0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response: refused words and unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == ADDR_STATUS) begin
        s_axi_bresp <= RESP_OKAY;
      end else if (aw_addr == ADDR_CMD && w_lane_ok && state != TRO_RPARAM) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign rd_cmd = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CMD && state == TRO_RPARAM;

  // Parameter word offered to the host for the current read opcode
  always_comb begin
    param_rd = 16'h0000;
    unique case (cur_op)
      OP_RD_DEAD: param_rd = {14'h0000, dead_code};
      OP_RD_HDR: param_rd = {15'h0000, hdr_trl_en};
      OP_RD_LIMIT: param_rd = {12'h000, hit_limit};
      OP_RD_ERREN: param_rd = {5'h00, err_type_en};
      OP_RD_BUF: param_rd = {13'h0000, buf_size};
      OP_RD_MASK: param_rd = chan_en[{word_idx, 4'h0} +: 16];
      default: param_rd = 16'h0000;
    endcase
  end

  // Read channel: one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == ADDR_CMD) begin
        s_axi_rdata <= rd_cmd ? {16'h0000, param_rd} : 32'h0000_0000;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        s_axi_rdata <= {16'h0000, opcode[15:8], 3'b000, word_idx, state == TRO_RPARAM, state == TRO_WPARAM};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Command sequencer: parameter words are consumed before any new opcode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= TRO_IDLE;
      opcode <= 16'h0000;
      word_idx <= 3'h0;
      last_idx <= 3'h0;
    end else begin
      unique case (state)
        TRO_IDLE: begin
          if (do_write && aw_addr == ADDR_CMD && w_lane_ok) begin
            opcode <= w_data;
            word_idx <= 3'h0;
            unique case (cmd_op)
              OP_SET_DEAD, OP_SET_LIMIT, OP_SET_ERREN, OP_SET_BUF: begin
                state <= TRO_WPARAM;
                last_idx <= 3'h0;
              end
              OP_WR_MASK: begin
                state <= TRO_WPARAM;
                last_idx <= MASK_WORDS_M1;
              end
              OP_WR_MASK32: begin
                state <= TRO_WPARAM;
                last_idx <= MASK32_WORDS_M1;
              end
              OP_RD_DEAD, OP_RD_HDR, OP_RD_LIMIT, OP_RD_ERREN, OP_RD_BUF: begin
                state <= TRO_RPARAM;
                last_idx <= 3'h0;
              end
              OP_RD_MASK: begin
                state <= TRO_RPARAM;
                last_idx <= MASK_WORDS_M1;
              end
              default: state <= TRO_IDLE;
            endcase
          end
        end
        TRO_WPARAM: begin
          if (do_write && aw_addr == ADDR_CMD && w_lane_ok) begin
            word_idx <= word_idx + 3'h1;
            if (word_idx == last_idx) begin
              state <= TRO_IDLE;
            end
          end
        end
        TRO_RPARAM: begin
          if (rd_cmd) begin
            word_idx <= word_idx + 3'h1;
            if (word_idx == last_idx) begin
              state <= TRO_IDLE;
            end
          end
        end
        default: state <= TRO_IDLE;
      endcase
    end
  end

  // Scalar settings from parameterless opcodes and one-word parameters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dead_code <= DEAD_RST;
      hdr_trl_en <= 1'b0;
      hit_limit <= LIMIT_RST;
      err_mark_en <= 1'b1;
      bypass_en <= 1'b0;
      err_type_en <= ERREN_RST;
      buf_size <= BUF_RST;
    end else if (do_write && aw_addr == ADDR_CMD && w_lane_ok) begin
      if (state == TRO_IDLE) begin
        unique case (cmd_op)
          OP_HDR_ON: hdr_trl_en <= 1'b1;
          OP_HDR_OFF: hdr_trl_en <= 1'b0;
          OP_MARK_ON: err_mark_en <= 1'b1;
          OP_MARK_OFF: err_mark_en <= 1'b0;
          OP_BYP_ON: bypass_en <= 1'b1;
          OP_BYP_OFF: bypass_en <= 1'b0;
          default: hdr_trl_en <= hdr_trl_en;
        endcase
      end else if (state == TRO_WPARAM) begin
        unique case (cur_op)
          OP_SET_DEAD: dead_code <= w_data[1:0];
          OP_SET_LIMIT: hit_limit <= w_data[3:0];
          OP_SET_ERREN: err_type_en <= w_data[ERR_TYPES-1:0];
          OP_SET_BUF: buf_size <= w_data[2:0];
          default: buf_size <= buf_size;
        endcase
      end
    end
  end

  // Dead time in clock cycles for the hit spacing logic
  always_comb begin
    unique case (dead_code)
      2'b00: dead_cycles = DEAD_CYC0;
      2'b01: dead_cycles = DEAD_CYC1;
      2'b10: dead_cycles = DEAD_CYC2;
      2'b11: dead_cycles = DEAD_CYC3;
    endcase
  end

  // Channel enables: changed at any time, acquisition keeps running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_en <= {NUM_CH{1'b1}};
    end else if (do_write && aw_addr == ADDR_CMD && w_lane_ok) begin
      if (state == TRO_IDLE) begin
        unique case (cmd_op)
          OP_CH_ON: if (!w_data[7]) chan_en[w_data[6:0]] <= 1'b1;
          OP_CH_OFF: if (!w_data[7]) chan_en[w_data[6:0]] <= 1'b0;
          OP_ALL_ON: chan_en <= {NUM_CH{1'b1}};
          OP_ALL_OFF: chan_en <= {NUM_CH{1'b0}};
          default: chan_en <= chan_en;
        endcase
      end else if (state == TRO_WPARAM && cur_op == OP_WR_MASK) begin
        chan_en[{word_idx, 4'h0} +: 16] <= w_data;
      end else if (state == TRO_WPARAM && cur_op == OP_WR_MASK32 && cur_tdc < 4'(NUM_TDC)) begin
        chan_en[{cur_tdc[1:0], word_idx[0], 4'h0} +: 16] <= w_data;
      end
    end
  end

  // Hit cap from the limit code; codes above 1000 leave hits unlimited
  always_comb begin
    if (hit_limit == 4'h0) begin
      hit_cap = 9'h000;
    end else if (hit_limit <= LIMIT_MAX_CODE) begin
      hit_cap = 9'h001 << (hit_limit - 4'h1);
    end else begin
      hit_cap = 9'h1FF;
    end
  end

  assign over_limit = hit_limit <= LIMIT_MAX_CODE && hit_cnt >= hit_cap;
  assign hit_accept = hit_in && !over_limit;

  // Hit counting per event; a hit past the cap marks the event oversize
  logic size_err;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_cnt <= 9'h000;
      size_err <= 1'b0;
    end else if (event_end) begin
      hit_cnt <= 9'h000;
      size_err <= 1'b0;
    end else if (hit_in) begin
      if (over_limit) begin
        size_err <= 1'b1;
      end else begin
        hit_cnt <= hit_cnt + 9'h001;
      end
    end
  end

  // Error word closes the event, then the trailer follows when enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_word_valid <= 1'b0;
      err_word <= 16'h0000;
      pend_trailer <= 1'b0;
      trailer_valid <= 1'b0;
    end else begin
      err_word_valid <= event_end && (size_err || (hit_in && over_limit));
      err_word <= SIZE_EXCEEDED_FLAG;
      pend_trailer <= event_end && hdr_trl_en;
      trailer_valid <= pend_trailer;
    end
  end

  // Global error from enabled types, with mark and bypass actions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_err <= 1'b0;
      err_mark <= 1'b0;
      tdc_bypass <= 1'b0;
    end else begin
      global_err <= |(tdc_err & err_type_en);
      err_mark <= err_mark_en && |(tdc_err & err_type_en);
      tdc_bypass <= bypass_en && |(tdc_err & err_type_en);
    end
  end

endmodule : tro_opcode_ctrl

// ===== include/tro_pkg.sv
// Package for the readout opcode interpreter: map, opcodes, field layouts, resets
package tro_pkg;
  // Register map (byte addresses) and response codes
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Opcode bytes
  localparam logic [7:0] OP_SET_DEAD = 8'h28;
  localparam logic [7:0] OP_RD_DEAD = 8'h29;
  localparam logic [7:0] OP_HDR_ON = 8'h30;
  localparam logic [7:0] OP_HDR_OFF = 8'h31;
  localparam logic [7:0] OP_RD_HDR = 8'h32;
  localparam logic [7:0] OP_SET_LIMIT = 8'h33;
  localparam logic [7:0] OP_RD_LIMIT = 8'h34;
  localparam logic [7:0] OP_MARK_ON = 8'h35;
  localparam logic [7:0] OP_MARK_OFF = 8'h36;
  localparam logic [7:0] OP_BYP_ON = 8'h37;
  localparam logic [7:0] OP_BYP_OFF = 8'h38;
  localparam logic [7:0] OP_SET_ERREN = 8'h39;
  localparam logic [7:0] OP_RD_ERREN = 8'h3A;
  localparam logic [7:0] OP_SET_BUF = 8'h3B;
  localparam logic [7:0] OP_RD_BUF = 8'h3C;
  localparam logic [7:0] OP_CH_ON = 8'h40;
  localparam logic [7:0] OP_CH_OFF = 8'h41;
  localparam logic [7:0] OP_ALL_ON = 8'h42;
  localparam logic [7:0] OP_ALL_OFF = 8'h43;
  localparam logic [7:0] OP_WR_MASK = 8'h44;
  localparam logic [7:0] OP_RD_MASK = 8'h45;
  localparam logic [7:0] OP_WR_MASK32 = 8'h46;
  // Sizes
  localparam int NUM_CH = 128;
  localparam int NUM_TDC = 4;
  localparam logic [2:0] MASK_WORDS_M1 = 3'h7;
  localparam logic [2:0] MASK32_WORDS_M1 = 3'h1;
  localparam int ERR_TYPES = 11;
  // Reset values, highest capped limit code, error word flag
  localparam logic [1:0] DEAD_RST = 2'b00;
  localparam logic [3:0] LIMIT_RST = 4'b1001;
  localparam logic [3:0] LIMIT_MAX_CODE = 4'b1000;
  localparam logic [2:0] BUF_RST = 3'b111;
  localparam logic [ERR_TYPES-1:0] ERREN_RST = 11'h000;
  localparam logic [15:0] SIZE_EXCEEDED_FLAG = 16'h1000;
  // Dead time settings in ns and in cycles at 125 MHz (rounded up)
  localparam int CLK_MHZ = 125;
  localparam int DEAD_NS0 = 5;
  localparam int DEAD_NS1 = 10;
  localparam int DEAD_NS2 = 30;
  localparam int DEAD_NS3 = 100;
  localparam logic [3:0] DEAD_CYC0 = 4'((DEAD_NS0 * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] DEAD_CYC1 = 4'((DEAD_NS1 * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] DEAD_CYC2 = 4'((DEAD_NS2 * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] DEAD_CYC3 = 4'((DEAD_NS3 * CLK_MHZ + 999) / 1000);

  // Interpreter states
  typedef enum logic [1:0] {TRO_IDLE, TRO_WPARAM, TRO_RPARAM} tro_state_t;

  // Configuration carried to the acquisition logic
  typedef struct packed {
    logic [1:0] dead_code;
    logic [3:0] dead_cycles;
    logic hdr_trl_en;
    logic [3:0] hit_limit;
    logic err_mark_en;
    logic bypass_en;
    logic [ERR_TYPES-1:0] err_type_en;
    logic [2:0] buf_size;
    logic [NUM_CH-1:0] chan_en;
  } tro_cfg_t;
endpackage : tro_pkg

// ===== testbench/tb_top.sv
// Self-checking bench for the opcode interpreter
`timescale 1ns/1ns
module tb_top;
  import tro_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic hit_in = 1'b0;
  logic event_end = 1'b0;
  logic [ERR_TYPES-1:0] tdc_err = '0;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic hit_accept, err_word_valid, trailer_valid, global_err, err_mark, tdc_bypass, m, bp, ge;
  logic [15:0] err_word, v;
  logic [7:0] b;
  logic [127:0] exp_ch;
  tro_cfg_t cfg;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 73;
  logic [7:0] sop[4] = '{OP_SET_DEAD, OP_SET_LIMIT, OP_SET_ERREN, OP_SET_BUF};
  logic [7:0] rop[4] = '{OP_RD_DEAD, OP_RD_LIMIT, OP_RD_ERREN, OP_RD_BUF};
  logic [15:0] msk[4] = '{16'h0003, 16'h000F, 16'h07FF, 16'h0007};
  logic [15:0] dflt[4] = '{16'(DEAD_RST), 16'(LIMIT_RST), 16'(ERREN_RST), 16'(BUF_RST)};
  logic [7:0] hop[3] = '{OP_HDR_ON, OP_HDR_OFF, OP_HDR_ON};
  int lc[6] = '{0, 1, 2, 3, 4, 9};
  always #4 aclk = ~aclk;
  tro_opcode_ctrl i_dut (.*);
  tro_host_model i_host (.*);
  // Compare and count
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Word written to the command location
  task automatic wr(input logic [15:0] w, input logic [1:0] er);
    i_host.wr(ADDR_CMD, {16'h0000, w}, r);
    chk(r, er);
  endtask : wr
  // Opcode with a random low byte, which must not matter
  task automatic cmd(input logic [7:0] op);
    wr({op, 8'($random(seed))}, RESP_OKAY);
  endtask : cmd
  task automatic rdc(input logic [15:0] e);
    i_host.rd(ADDR_CMD, d, r);
    chk({r, d}, {RESP_OKAY, 16'h0000, e});
  endtask : rdc
  task automatic chkmask();
    cmd(OP_RD_MASK);
    for (int w = 0; w < 8; w++) rdc(exp_ch[16*w+:16]);
    chk(cfg.chan_en, exp_ch);
  endtask : chkmask
  function automatic int cap(input int code);
    return (code > 8) ? -1 : (code == 0) ? 0 : 1 << (code - 1);
  endfunction : cap
  // One event of nh hits against cap cp (negative: no cap)
  task automatic evt(input int nh, input int cp, input logic tr);
    int acc;
    acc = 0;
    for (int k = 0; k < nh; k++) begin
      @(posedge aclk);
      hit_in <= 1'b1;
      event_end <= (k == nh - 1);
      @(negedge aclk);
      acc += int'(hit_accept);
    end
    @(posedge aclk);
    hit_in <= 1'b0;
    event_end <= 1'b0;
    @(negedge aclk);
    chk(acc, (cp < 0 || nh <= cp) ? nh : cp);
    chk(err_word_valid, cp >= 0 && nh > cp);
    if (cp >= 0 && nh > cp) chk(err_word, SIZE_EXCEEDED_FLAG);
    chk(trailer_valid, 1'b0);
    @(negedge aclk);
    chk(trailer_valid, tr);
  endtask : evt
  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    exp_ch = '1;
    for (int i = 0; i < 4; i++) begin
      cmd(rop[i]);
      rdc(dflt[i]);
      repeat (3) begin
        v = 16'($random(seed));
        if (i == 1) v[3:0] = v[3:0] % 4'd10;
        cmd(sop[i]);
        wr(v, RESP_OKAY);
        cmd(rop[i]);
        rdc(v & msk[i]);
      end
    end
    cmd(OP_RD_HDR);
    rdc(16'h0000);
    cmd(OP_SET_DEAD);
    i_host.rd(ADDR_STATUS, d, r);
    chk(d[15:0] & 16'hFF01, {OP_SET_DEAD, 8'h01});
    wr(16'h3000, RESP_OKAY);
    cmd(OP_RD_HDR);
    rdc(16'h0000);
    cmd(OP_RD_DEAD);
    wr(16'h3000, RESP_SLVERR);
    rdc(16'h0000);
    i_host.rd(4'h8, d, r);
    chk(r, RESP_SLVERR);
    foreach (hop[i]) begin
      cmd(hop[i]);
      cmd(OP_RD_HDR);
      rdc(16'(i != 1));
    end
    cmd(OP_ALL_OFF);
    exp_ch = '0;
    chkmask();
    repeat (6) begin
      b = 8'($random(seed)) & 8'h7F;
      m = 1'($random(seed));
      wr({m ? OP_CH_ON : OP_CH_OFF, b}, RESP_OKAY);
      exp_ch[b] = m;
      chk(cfg.chan_en, exp_ch);
    end
    cmd(OP_ALL_ON);
    exp_ch = '1;
    chkmask();
    cmd(OP_WR_MASK);
    for (int w = 0; w < 8; w++) begin
      v = 16'($random(seed));
      wr(v, RESP_OKAY);
      exp_ch[16*w+:16] = v;
    end
    chkmask();
    b = 8'($random(seed)) & 8'h03;
    wr({OP_WR_MASK32, b}, RESP_OKAY);
    for (int w = 0; w < 2; w++) begin
      v = 16'($random(seed));
      wr(v, RESP_OKAY);
      exp_ch[32*b+16*w+:16] = v;
    end
    chkmask();
    foreach (lc[i]) begin
      cmd(OP_SET_LIMIT);
      wr(16'(lc[i]), RESP_OKAY);
      evt(cap(lc[i]) < 0 ? 5 : cap(lc[i]) + 1, cap(lc[i]), 1'b1);
    end
    cmd(OP_HDR_OFF);
    evt(3, -1, 1'b0);
    repeat (6) begin
      v = 16'($random(seed));
      m = 1'($random(seed));
      bp = 1'($random(seed));
      cmd(OP_SET_ERREN);
      wr(v, RESP_OKAY);
      cmd(m ? OP_MARK_ON : OP_MARK_OFF);
      cmd(bp ? OP_BYP_ON : OP_BYP_OFF);
      @(posedge aclk);
      tdc_err <= ERR_TYPES'($random(seed));
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      ge = |(tdc_err & v[ERR_TYPES-1:0]);
      chk(global_err, ge);
      chk(err_mark, ge & m);
      chk(tdc_bypass, ge & bp);
    end
    print_verdict();
  end
endmodule : tb_top

// ===== testbench/tro_host_model.sv
// Host model: AXI4-Lite master issuing opcode and parameter words
`timescale 1ns/1ns
module tro_host_model (
  input wire logic aclk, // Clock
  output logic [3:0] s_axi_awaddr, // Write address
  output logic s_axi_awvalid, // Address valid
  input wire logic s_axi_awready, // Address ready
  output logic [31:0] s_axi_wdata, // Write data
  output logic [3:0] s_axi_wstrb, // Byte enables
  output logic s_axi_wvalid, // Data valid
  input wire logic s_axi_wready, // Data ready
  input wire logic [1:0] s_axi_bresp, // Response
  input wire logic s_axi_bvalid, // Response valid
  output logic s_axi_bready, // Response ready
  output logic [3:0] s_axi_araddr, // Read address
  output logic s_axi_arvalid, // Read valid
  input wire logic s_axi_arready, // Read ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  output logic s_axi_rready // Read data ready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // A hung transfer ends the run
  task automatic tmo();
    tb_top.n_mismatch++;
    tb_top.print_verdict();
  endtask : tmo
  // One write: address and data together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 99);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) tmo();
  endtask : wr
  // One read, data taken at the edge that sees rvalid
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 99);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) tmo();
  endtask : rd
endmodule : tro_host_model

// ===== testbench/tro_opcode_ctrl_properties.sv
// Checker for the opcode interpreter, bound to its top module
`timescale 1ns/1ns
module tro_opcode_ctrl_properties
  import tro_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic hit_in, // Hit
  input wire logic event_end, // Event end
  input wire logic [ERR_TYPES-1:0] tdc_err, // Error levels
  input wire logic hit_accept, // Hit kept
  input wire logic err_word_valid, // Error word strobe
  input wire logic [15:0] err_word, // Error word
  input wire logic trailer_valid, // Trailer slot
  input wire logic global_err, // Global error
  input wire logic err_mark, // Error mark
  input wire logic tdc_bypass, // Bypass
  input wire tro_cfg_t cfg // Configuration
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_flag_value: assert property (err_word_valid |-> err_word == SIZE_EXCEEDED_FLAG)
    else $error("error word flag wrong");
  a_flag_timing: assert property (err_word_valid |-> $past(event_end))
    else $error("error word not after event end");
  a_trailer_after: assert property (err_word_valid && $past(cfg.hdr_trl_en) |=> trailer_valid)
    else $error("trailer not after error word");
  a_trailer_slot: assert property (trailer_valid |-> $past(event_end, 2) && $past(cfg.hdr_trl_en, 2))
    else $error("trailer out of place");
  a_zero_cap: assert property (hit_in && cfg.hit_limit == 4'h0 |-> !hit_accept)
    else $error("hit kept with zero cap");
  a_no_cap: assert property (hit_in && cfg.hit_limit > LIMIT_MAX_CODE |-> hit_accept)
    else $error("hit dropped without cap");
  a_global_err: assert property (global_err == |($past(tdc_err) & $past(cfg.err_type_en)))
    else $error("global error not masked sum");
  a_mark_gate: assert property (err_mark == (global_err && $past(cfg.err_mark_en)))
    else $error("error mark wrong");
  a_bypass_gate: assert property (tdc_bypass == (global_err && $past(cfg.bypass_en)))
    else $error("bypass wrong");
  a_dead_cycles: assert property (cfg.dead_cycles == (cfg.dead_code == 2'd0 ? DEAD_CYC0 :
    cfg.dead_code == 2'd1 ? DEAD_CYC1 : cfg.dead_code == 2'd2 ? DEAD_CYC2 : DEAD_CYC3))
    else $error("dead cycles wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  c_err_word: cover property (err_word_valid);
  c_trailer: cover property (trailer_valid);
  c_bypass: cover property (tdc_bypass);
endmodule : tro_opcode_ctrl_properties

bind tro_opcode_ctrl tro_opcode_ctrl_properties i_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .hit_in(hit_in),
  .event_end(event_end),
  .tdc_err(tdc_err),
  .hit_accept(hit_accept),
  .err_word_valid(err_word_valid),
  .err_word(err_word),
  .trailer_valid(trailer_valid),
  .global_err(global_err),
  .err_mark(err_mark),
  .tdc_bypass(tdc_bypass),
  .cfg(cfg)
);
